// >>> hdl/erm_matrix.sv
// Event routing matrix: channel source muxes, user muxes, software strobes and register file.
// How it works
// - Writing a one to a strobe bit inverts that channel for exactly one clock, seen by all its users.
// - Four asynchronous source selectors sit at 0x02 to 0x05 and reset to zero, meaning unconnected.
// - Async source codes 0x01 to 0x09 pick the logic tables, comparator zero, control timer and real-time events.
// - Codes 0x0a to 0x14 pick port pins, periodic taps, comparators one and two or the debug line per channel.
// - Two synchronous source selectors sit at 0x0a and 0x0b and reset to zero, meaning unconnected.
// - Sync source codes pick capture timers, main timer events and port pins as laid out per channel.
// - Thirteen async-capable user selectors sit from 0x12 on, each serving one fixed user.
// - An async-capable user selector maps 1 and 2 to the sync channels and 3 to 6 to the async channels.
// - Two sync-only user selectors at 0x22 and 0x23 serve the main timer and serial port and reset to off.
// - A sync-only user selector maps 1 and 2 to the sync channels and can never reach an async channel.
// - Pulses and levels from generators pass through the matrix unchanged.
// - Strobes need the clock, while the configured routing paths are purely combinational.
// - Async events are synchronised inside users, and sync-only users see only sync channels.
module erm_matrix (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire erm_pkg::erm_async_gen_s async_gen,
  input wire erm_pkg::erm_sync_gen_s sync_gen,
  output erm_pkg::erm_user_evt_s user_evt
);
  import erm_pkg::*;

  logic [7:0] async_strobe;
  logic [7:0] sync_strobe;
  logic [7:0] async_src [ERM_ASYNC_CH];
  logic [7:0] sync_src [ERM_SYNC_CH];
  logic [7:0] async_user [ERM_ASYNC_USERS];
  logic [7:0] sync_user [ERM_SYNC_USERS];
  logic [ERM_ASYNC_CH-1:0] async_pulse;
  logic [ERM_SYNC_CH-1:0] sync_pulse;
  logic [7:0] next_async_strobe;
  logic [7:0] next_sync_strobe;
  logic [7:0] next_async_src [ERM_ASYNC_CH];
  logic [7:0] next_sync_src [ERM_SYNC_CH];
  logic [7:0] next_async_user [ERM_ASYNC_USERS];
  logic [7:0] next_sync_user [ERM_SYNC_USERS];
  logic [ERM_ASYNC_CH-1:0] next_async_pulse;
  logic [ERM_SYNC_CH-1:0] next_sync_pulse;
  logic [7:0] next_reg_rdata;
  logic [ERM_ASYNC_CH-1:0] async_chan;
  logic [ERM_SYNC_CH-1:0] sync_chan;
  logic [ERM_ASYNC_USERS-1:0] async_user_evt;
  logic [ERM_SYNC_USERS-1:0] sync_user_evt;

  function automatic logic in_range(input logic [7:0] code, input logic [7:0] lo, input logic [7:0] hi);
    return (code >= lo) && (code <= hi);
  endfunction

  function automatic logic [2:0] pin_index(input logic [7:0] code, input logic [7:0] first);
    logic [7:0] diff;
    diff = code - first;
    return diff[2:0];
  endfunction

  // Source pick for one asynchronous channel.
  function automatic logic async_pick(input int ch, input logic [7:0] code, input erm_async_gen_s g);
    logic r;
    logic [2:0] idx;
    r = 1'b0;
    idx = pin_index(code, ERM_ASRC_PIN_FIRST);
    unique case (code)
      ERM_ASRC_LT0: r = g.logic_table_zero_out;
      ERM_ASRC_LT1: r = g.logic_table_one_out;
      ERM_ASRC_CMP0: r = g.comparator_zero_out;
      ERM_ASRC_CT_BCLR: r = g.control_timer_cmp_b_clear;
      ERM_ASRC_CT_ASET: r = g.control_timer_cmp_a_set;
      ERM_ASRC_CT_BSET: r = g.control_timer_cmp_b_set;
      ERM_ASRC_CT_PROG: r = g.control_timer_prog_event;
      ERM_ASRC_RT_OVF: r = g.realtime_overflow;
      ERM_ASRC_RT_CMP: r = g.realtime_compare;
      default: r = 1'b0;
    endcase
    // Channel specific pins, taps and comparators.
    if (in_range(code, ERM_ASRC_PIN_FIRST, ERM_ASRC_PIN_LAST)) begin
      if (ch == 0) begin
        r = g.port_a_line[idx];
      end else if (ch == 1) begin
        r = g.port_b_line[idx];
      end else if (ch == 2) begin
        if (idx == ERM_PORT_C_CMP1_IDX) begin
          r = g.comparator_one_out;
        end else if (idx == ERM_PORT_C_CMP2_IDX) begin
          r = g.comparator_two_out;
        end else begin
          r = g.port_c_line[idx];
        end
      end else begin
        r = g.periodic_tap[idx];
      end
    end
    if (ch == 0) begin
      if (code == ERM_ASRC_HI0) begin
        r = g.debug_link_line;
      end else if (code == ERM_ASRC_HI1) begin
        r = g.comparator_one_out;
      end else if (code == ERM_ASRC_HI2) begin
        r = g.comparator_two_out;
      end
    end else if (ch != 2) begin
      if (code == ERM_ASRC_HI0) begin
        r = g.comparator_one_out;
      end else if (code == ERM_ASRC_HI1) begin
        r = g.comparator_two_out;
      end
    end
    return r;
  endfunction

  // Source pick for one synchronous channel.
  function automatic logic sync_pick(input int ch, input logic [7:0] code, input erm_sync_gen_s g);
    logic r;
    r = 1'b0;
    // Shared and per channel sync sources.
    if (code == ERM_SSRC_CAP0) begin
      r = g.capture_timer_zero;
    end else if (code == ERM_SSRC_MT_OVF) begin
      r = g.main_timer_overflow;
    end else if (code == ERM_SSRC_MT_CMP2) begin
      r = g.main_timer_compare_two;
    end else if (ch == 0) begin
      if (in_range(code, ERM_SSRC0_PC_FIRST, ERM_SSRC0_PC_LAST)) begin
        r = g.port_c_line[pin_index(code, ERM_SSRC0_PC_FIRST)];
      end else if (in_range(code, ERM_SSRC0_PA_FIRST, ERM_SSRC0_PA_LAST)) begin
        r = g.port_a_line[pin_index(code, ERM_SSRC0_PA_FIRST)];
      end else if (code == ERM_SSRC0_CAP1) begin
        r = g.capture_timer_one;
      end
    end else begin
      if (in_range(code, ERM_SSRC1_PB_FIRST, ERM_SSRC1_PB_LAST)) begin
        r = g.port_b_line[pin_index(code, ERM_SSRC1_PB_FIRST)];
      end else if (code == ERM_SSRC1_CAP1) begin
        r = g.capture_timer_one;
      end
    end
    return r;
  endfunction

  // Channel pick for a user; async_ok is low for sync-only users.
  function automatic logic user_pick(input logic [7:0] sel, input logic async_ok, input logic [1:0] sch,
                                     input logic [3:0] ach);
    logic r;
    logic [7:0] diff;
    r = 1'b0;
    diff = sel - ERM_USR_ASYNC0;
    if (sel == ERM_USR_SYNC0) begin
      r = sch[0];
    end else if (sel == ERM_USR_SYNC1) begin
      r = sch[1];
    end else if (async_ok && in_range(sel, ERM_USR_ASYNC0, ERM_USR_ASYNC3)) begin
      r = ach[diff[1:0]];
    end
    return r;
  endfunction

  // Register writes, strobe pulses and read data.
  always_comb begin
    next_async_strobe = async_strobe;
    next_sync_strobe = sync_strobe;
    next_async_src = async_src;
    next_sync_src = sync_src;
    next_async_user = async_user;
    next_sync_user = sync_user;
    next_async_pulse = '0;
    next_sync_pulse = '0;
    next_reg_rdata = 8'h00;
    if (reg_wr) begin
      // Strobe writes arm a one-cycle inversion.
      if (reg_addr == ERM_OFF_ASYNC_STROBE) begin
        next_async_strobe = reg_wdata;
        next_async_pulse = reg_wdata[ERM_ASYNC_CH-1:0];
      end
      if (reg_addr == ERM_OFF_SYNC_STROBE) begin
        next_sync_strobe = reg_wdata;
        next_sync_pulse = reg_wdata[ERM_SYNC_CH-1:0];
      end
      for (int i = 0; i < ERM_ASYNC_CH; i++) begin
        if (reg_addr == ERM_OFF_ASYNC_SRC + 8'(i)) begin
          next_async_src[i] = reg_wdata;
        end
      end
      for (int i = 0; i < ERM_SYNC_CH; i++) begin
        if (reg_addr == ERM_OFF_SYNC_SRC + 8'(i)) begin
          next_sync_src[i] = reg_wdata;
        end
      end
      for (int i = 0; i < ERM_ASYNC_USERS; i++) begin
        if (reg_addr == ERM_OFF_ASYNC_USER + 8'(i)) begin
          next_async_user[i] = reg_wdata;
        end
      end
      for (int i = 0; i < ERM_SYNC_USERS; i++) begin
        if (reg_addr == ERM_OFF_SYNC_USER + 8'(i)) begin
          next_sync_user[i] = reg_wdata;
        end
      end
    end
    if (reg_rd) begin
      if (reg_addr == ERM_OFF_ASYNC_STROBE) begin
        next_reg_rdata = async_strobe;
      end
      if (reg_addr == ERM_OFF_SYNC_STROBE) begin
        next_reg_rdata = sync_strobe;
      end
      for (int i = 0; i < ERM_ASYNC_CH; i++) begin
        if (reg_addr == ERM_OFF_ASYNC_SRC + 8'(i)) begin
          next_reg_rdata = async_src[i];
        end
      end
      for (int i = 0; i < ERM_SYNC_CH; i++) begin
        if (reg_addr == ERM_OFF_SYNC_SRC + 8'(i)) begin
          next_reg_rdata = sync_src[i];
        end
      end
      for (int i = 0; i < ERM_ASYNC_USERS; i++) begin
        if (reg_addr == ERM_OFF_ASYNC_USER + 8'(i)) begin
          next_reg_rdata = async_user[i];
        end
      end
      for (int i = 0; i < ERM_SYNC_USERS; i++) begin
        if (reg_addr == ERM_OFF_SYNC_USER + 8'(i)) begin
          next_reg_rdata = sync_user[i];
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      async_strobe <= ERM_REG_RESET;
      sync_strobe <= ERM_REG_RESET;
      async_src <= '{default: ERM_REG_RESET};
      sync_src <= '{default: ERM_REG_RESET};
      async_user <= '{default: ERM_REG_RESET};
      sync_user <= '{default: ERM_REG_RESET};
      async_pulse <= '0;
      sync_pulse <= '0;
      reg_rdata <= 8'h00;
    end else begin
      async_strobe <= next_async_strobe;
      sync_strobe <= next_sync_strobe;
      async_src <= next_async_src;
      sync_src <= next_sync_src;
      async_user <= next_async_user;
      sync_user <= next_sync_user;
      async_pulse <= next_async_pulse;
      sync_pulse <= next_sync_pulse;
      reg_rdata <= next_reg_rdata;
    end
  end

  // Routing is combinational so configured paths work with the clock stopped; levels and pulses pass as-is.
  // Clockless routing path.
  always_comb begin
    for (int c = 0; c < ERM_ASYNC_CH; c++) begin
      async_chan[c] = async_pick(c, async_src[c], async_gen) ^ async_pulse[c];
    end
    for (int c = 0; c < ERM_SYNC_CH; c++) begin
      sync_chan[c] = sync_pick(c, sync_src[c], sync_gen) ^ sync_pulse[c];
    end
    for (int u = 0; u < ERM_ASYNC_USERS; u++) begin
      async_user_evt[u] = user_pick(async_user[u], 1'b1, sync_chan, async_chan);
    end
    // Sync-only users never see async channels.
    for (int u = 0; u < ERM_SYNC_USERS; u++) begin
      sync_user_evt[u] = user_pick(sync_user[u], 1'b0, sync_chan, async_chan);
    end
  end

  always_comb begin
    user_evt.capture_timer_zero = async_user_evt[0];
    user_evt.converter_zero = async_user_evt[1];
    user_evt.logic_table_zero_input_zero = async_user_evt[2];
    user_evt.logic_table_one_input_zero = async_user_evt[3];
    user_evt.logic_table_zero_input_one = async_user_evt[4];
    user_evt.logic_table_one_input_one = async_user_evt[5];
    user_evt.control_timer_input_zero = async_user_evt[6];
    user_evt.control_timer_input_one = async_user_evt[7];
    user_evt.event_pin_out_zero = async_user_evt[8];
    user_evt.event_pin_out_one = async_user_evt[9];
    user_evt.event_pin_out_two = async_user_evt[10];
    user_evt.capture_timer_one = async_user_evt[11];
    user_evt.converter_one = async_user_evt[12];
    user_evt.main_timer = sync_user_evt[0];
    user_evt.serial_port_zero = sync_user_evt[1];
  end

  AST_ASYNC_STROBE_PULSE: assert property (@(posedge ref_clk) disable iff (rst)
    (reg_wr && reg_addr == ERM_OFF_ASYNC_STROBE) |=> (async_pulse == $past(reg_wdata[3:0])))
    else $error("async strobe pulse does not match written bits");

  AST_STROBE_ENDS: assert property (@(posedge ref_clk) disable iff (rst)
    !(reg_wr && reg_addr <= ERM_OFF_SYNC_STROBE) |=> (async_pulse == '0 && sync_pulse == '0))
    else $error("strobe pulse lasted more than one cycle");

  AST_STROBE_SEEN_BY_USER: assert property (@(posedge ref_clk) disable iff (rst)
    (async_src[0] == ERM_SRC_OFF && async_user[8] == ERM_USR_ASYNC0 && reg_wr
     && reg_addr == ERM_OFF_ASYNC_STROBE && reg_wdata[0])
    |=> user_evt.event_pin_out_zero ##1 (!async_pulse[0] || $past(reg_wr)))
    else $error("strobe not seen by user for one cycle");

  AST_SRC_RESET: assert property (@(posedge ref_clk)
    rst |=> (async_src[0] == ERM_REG_RESET && async_src[3] == ERM_REG_RESET && sync_src[1] == ERM_REG_RESET))
    else $error("source selector not cleared by reset");

  AST_CMP0_ROUTE: assert property (@(posedge ref_clk) disable iff (rst)
    (async_src[1] == ERM_ASRC_CMP0 && !async_pulse[1]) |-> (async_chan[1] == async_gen.comparator_zero_out))
    else $error("comparator zero not routed on async channel one");

  AST_TAP_ROUTE: assert property (@(posedge ref_clk) disable iff (rst)
    (async_src[3] == ERM_ASRC_PIN_LAST && !async_pulse[3]) |-> (async_chan[3] == async_gen.periodic_tap[7]))
    else $error("last periodic tap not routed on async channel three");

  AST_SYNC_WRITE: assert property (@(posedge ref_clk) disable iff (rst)
    (reg_wr && reg_addr == ERM_OFF_SYNC_SRC + 8'h01) |=> (sync_src[1] == $past(reg_wdata)))
    else $error("sync source selector one did not take the write");

  AST_SYNC_CAP1: assert property (@(posedge ref_clk) disable iff (rst)
    (sync_src[0] == ERM_SSRC0_CAP1 && !sync_pulse[0]) |-> (sync_chan[0] == sync_gen.capture_timer_one))
    else $error("capture timer one not routed on sync channel zero");

  AST_USER_MAP: assert property (@(posedge ref_clk) disable iff (rst)
    (async_user[12] == ERM_USR_ASYNC3) |-> (user_evt.converter_one == async_chan[3]))
    else $error("async user does not follow async channel three");

  AST_SYNC_USER_ONLY: assert property (@(posedge ref_clk) disable iff (rst)
    (sync_user[1] > ERM_USR_SYNC1) |-> !user_evt.serial_port_zero)
    else $error("sync-only user reached a non-sync selection");

  AST_UNLISTED_OFF: assert property (@(posedge ref_clk) disable iff (rst)
    (async_src[2] > ERM_ASRC_PIN_LAST) |-> (async_chan[2] == async_pulse[2]))
    else $error("unlisted source code connected a generator");

  AST_READ_BACK: assert property (@(posedge ref_clk) disable iff (rst)
    (reg_rd && reg_addr == ERM_OFF_ASYNC_USER) |=> (reg_rdata == $past(async_user[0])))
    else $error("read of first user selector returned wrong data");

  AST_SYNC_STROBE_PULSE: assert property (@(posedge ref_clk) disable iff (rst)
    (reg_wr && reg_addr == ERM_OFF_SYNC_STROBE) |=> (sync_pulse == $past(reg_wdata[1:0])))
    else $error("sync strobe pulse does not match written bits");

  AST_USER_RESET: assert property (@(posedge ref_clk)
    rst |=> (sync_user[0] == ERM_USR_OFF && sync_user[1] == ERM_USR_OFF && async_user[12] == ERM_USR_OFF))
    else $error("user selector not cleared by reset");

  AST_SYNC_USER_MAP: assert property (@(posedge ref_clk) disable iff (rst)
    (sync_user[0] == ERM_USR_SYNC1) |-> (user_evt.main_timer == sync_chan[1]))
    else $error("sync-only user does not follow sync channel one");

  AST_SYNC_USER_NO_ASYNC: assert property (@(posedge ref_clk) disable iff (rst)
    (sync_user[0] >= ERM_USR_ASYNC0 && sync_user[0] <= ERM_USR_ASYNC3) |-> !user_evt.main_timer)
    else $error("sync-only user reached an asynchronous channel");

  COV_ASYNC_STROBE: cover property (@(posedge ref_clk) disable iff (rst)
    reg_wr && reg_addr == ERM_OFF_ASYNC_STROBE ##1 async_pulse != '0);
  COV_SYNC_ROUTE: cover property (@(posedge ref_clk) disable iff (rst)
    sync_user[0] == ERM_USR_SYNC1 && user_evt.main_timer);
  COV_PIN_OUT: cover property (@(posedge ref_clk) disable iff (rst)
    async_user[9] == ERM_USR_ASYNC0 && $rose(user_evt.event_pin_out_one));
endmodule

// >>> hdl/erm_pkg.sv
// Package with register map, source codes and event carriers of the event routing matrix.
package erm_pkg;
  localparam int ERM_ASYNC_CH = 4;
  localparam int ERM_SYNC_CH = 2;
  localparam int ERM_ASYNC_USERS = 13;
  localparam int ERM_SYNC_USERS = 2;
  localparam logic [7:0] ERM_REG_RESET = 8'h00;

  // Register byte offsets.
  localparam logic [7:0] ERM_OFF_ASYNC_STROBE = 8'h00;
  localparam logic [7:0] ERM_OFF_SYNC_STROBE = 8'h01;
  localparam logic [7:0] ERM_OFF_ASYNC_SRC = 8'h02;
  localparam logic [7:0] ERM_OFF_SYNC_SRC = 8'h0a;
  localparam logic [7:0] ERM_OFF_ASYNC_USER = 8'h12;
  localparam logic [7:0] ERM_OFF_SYNC_USER = 8'h22;

  // Asynchronous channel source codes.
  localparam logic [7:0] ERM_SRC_OFF = 8'h00;
  localparam logic [7:0] ERM_ASRC_LT0 = 8'h01;
  localparam logic [7:0] ERM_ASRC_LT1 = 8'h02;
  localparam logic [7:0] ERM_ASRC_CMP0 = 8'h03;
  localparam logic [7:0] ERM_ASRC_CT_BCLR = 8'h04;
  localparam logic [7:0] ERM_ASRC_CT_ASET = 8'h05;
  localparam logic [7:0] ERM_ASRC_CT_BSET = 8'h06;
  localparam logic [7:0] ERM_ASRC_CT_PROG = 8'h07;
  localparam logic [7:0] ERM_ASRC_RT_OVF = 8'h08;
  localparam logic [7:0] ERM_ASRC_RT_CMP = 8'h09;
  localparam logic [7:0] ERM_ASRC_PIN_FIRST = 8'h0a;
  localparam logic [7:0] ERM_ASRC_PIN_LAST = 8'h11;
  localparam logic [7:0] ERM_ASRC_HI0 = 8'h12;
  localparam logic [7:0] ERM_ASRC_HI1 = 8'h13;
  localparam logic [7:0] ERM_ASRC_HI2 = 8'h14;
  localparam logic [2:0] ERM_PORT_C_CMP1_IDX = 3'h6;
  localparam logic [2:0] ERM_PORT_C_CMP2_IDX = 3'h7;

  // Synchronous channel source codes.
  localparam logic [7:0] ERM_SSRC_CAP0 = 8'h01;
  localparam logic [7:0] ERM_SSRC_MT_OVF = 8'h02;
  localparam logic [7:0] ERM_SSRC_MT_CMP2 = 8'h06;
  localparam logic [7:0] ERM_SSRC0_PC_FIRST = 8'h07;
  localparam logic [7:0] ERM_SSRC0_PC_LAST = 8'h0c;
  localparam logic [7:0] ERM_SSRC0_PA_FIRST = 8'h0d;
  localparam logic [7:0] ERM_SSRC0_PA_LAST = 8'h14;
  localparam logic [7:0] ERM_SSRC0_CAP1 = 8'h15;
  localparam logic [7:0] ERM_SSRC1_PB_FIRST = 8'h08;
  localparam logic [7:0] ERM_SSRC1_PB_LAST = 8'h0f;
  localparam logic [7:0] ERM_SSRC1_CAP1 = 8'h10;

  // User selector codes.
  localparam logic [7:0] ERM_USR_OFF = 8'h00;
  localparam logic [7:0] ERM_USR_SYNC0 = 8'h01;
  localparam logic [7:0] ERM_USR_SYNC1 = 8'h02;
  localparam logic [7:0] ERM_USR_ASYNC0 = 8'h03;
  localparam logic [7:0] ERM_USR_ASYNC3 = 8'h06;

  // Asynchronous generators; periodic_tap bit 0 is divide by 8192, bit 7 divide by 64.
  typedef struct packed {
    logic logic_table_zero_out;
    logic logic_table_one_out;
    logic comparator_zero_out;
    logic comparator_one_out;
    logic comparator_two_out;
    logic control_timer_cmp_b_clear;
    logic control_timer_cmp_a_set;
    logic control_timer_cmp_b_set;
    logic control_timer_prog_event;
    logic realtime_overflow;
    logic realtime_compare;
    logic debug_link_line;
    logic [7:0] port_a_line;
    logic [7:0] port_b_line;
    logic [5:0] port_c_line;
    logic [7:0] periodic_tap;
  } erm_async_gen_s;

  typedef struct packed {
    logic capture_timer_zero;
    logic capture_timer_one;
    logic main_timer_overflow;
    logic main_timer_compare_two;
    logic [7:0] port_a_line;
    logic [7:0] port_b_line;
    logic [5:0] port_c_line;
  } erm_sync_gen_s;

  typedef struct packed {
    logic capture_timer_zero;
    logic converter_zero;
    logic logic_table_zero_input_zero;
    logic logic_table_one_input_zero;
    logic logic_table_zero_input_one;
    logic logic_table_one_input_one;
    logic control_timer_input_zero;
    logic control_timer_input_one;
    logic event_pin_out_zero;
    logic event_pin_out_one;
    logic event_pin_out_two;
    logic capture_timer_one;
    logic converter_one;
    logic main_timer;
    logic serial_port_zero;
  } erm_user_evt_s;
endpackage

// >>> tb/erm_gen_model.sv
// Model of the on-chip event generators that feed the routing matrix.
module erm_gen_model (
  input wire logic ref_clk,
  input wire logic pulse_mode,
  input wire logic fire,
  input wire erm_pkg::erm_async_gen_s a_req,
  input wire erm_pkg::erm_sync_gen_s s_req,
  output erm_pkg::erm_async_gen_s async_gen,
  output erm_pkg::erm_sync_gen_s sync_gen
);
  timeunit 1ns;
  timeprecision 1ps;
  import erm_pkg::*;
  erm_async_gen_s a_q = '0;
  erm_sync_gen_s s_q = '0;
  // Pulse generators hold an event for one clock, level generators follow their request.
  always @(posedge ref_clk) begin
    a_q <= fire ? a_req : '0;
    s_q <= fire ? s_req : '0;
  end
  assign async_gen = pulse_mode ? a_q : a_req;
  assign sync_gen = pulse_mode ? s_q : s_req;
endmodule

// >>> tb/erm_matrix_tb.sv
// Self-checking testbench of the event routing matrix.
module erm_matrix_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import erm_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic pulse_mode = 1'b0;
  logic fire = 1'b0;
  erm_async_gen_s a_req = '0;
  erm_sync_gen_s s_req = '0;
  erm_async_gen_s async_gen;
  erm_sync_gen_s sync_gen;
  erm_user_evt_s user_evt;
  erm_async_gen_s ga;
  erm_sync_gen_s gs;
  logic hit;
  int fail_count = 0;
  int tests_run = 0;

  erm_matrix u_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .async_gen(async_gen),
    .sync_gen(sync_gen), .user_evt(user_evt));
  erm_gen_model u_gen (.ref_clk(ref_clk), .pulse_mode(pulse_mode), .fire(fire), .a_req(a_req),
    .s_req(s_req), .async_gen(async_gen), .sync_gen(sync_gen));

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish();
    if (fail_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] exp);
    tests_run++;
    if (reg_rdata !== exp) begin
      fail_count++;
      $display("[FAIL] reg_rdata expected %h seen %h", exp, reg_rdata);
    end
  endtask

  task automatic chk_evt(input logic [14:0] exp);
    tests_run++;
    if (user_evt !== exp) begin
      fail_count++;
      $display("[FAIL] user_evt expected %h seen %h", exp, user_evt);
    end
  endtask

  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= addr;
    reg_wdata <= data;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic reg_read(input logic [7:0] addr, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= addr;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk_byte(exp);
  endtask

  task automatic drive(input erm_async_gen_s a, input erm_sync_gen_s s);
    @(posedge ref_clk);
    a_req <= a;
    s_req <= s;
    #1;
  endtask

  // One generator high for a listed code, all high for a code that must connect nothing.
  function automatic erm_async_gen_s async_pick(input int ch, input int c);
    erm_async_gen_s g;
    g = '0;
    hit = 1'b1;
    case (c)
      1: g.logic_table_zero_out = 1'b1;
      2: g.logic_table_one_out = 1'b1;
      3: g.comparator_zero_out = 1'b1;
      4: g.control_timer_cmp_b_clear = 1'b1;
      5: g.control_timer_cmp_a_set = 1'b1;
      6: g.control_timer_cmp_b_set = 1'b1;
      7: g.control_timer_prog_event = 1'b1;
      8: g.realtime_overflow = 1'b1;
      9: g.realtime_compare = 1'b1;
      default: begin
        if (c >= 10 && c <= 17) begin
          if (ch == 0) g.port_a_line[c - 10] = 1'b1;
          else if (ch == 1) g.port_b_line[c - 10] = 1'b1;
          else if (ch == 3) g.periodic_tap[c - 10] = 1'b1;
          else if (c < 16) g.port_c_line[c - 10] = 1'b1;
          else if (c == 16) g.comparator_one_out = 1'b1;
          else g.comparator_two_out = 1'b1;
        end else if (c == 18 && ch == 0) g.debug_link_line = 1'b1;
        else if ((c == 18 && ch != 2) || (c == 19 && ch == 0)) g.comparator_one_out = 1'b1;
        else if ((c == 19 && ch != 2) || (c == 20 && ch == 0)) g.comparator_two_out = 1'b1;
        else begin
          g = '1;
          hit = 1'b0;
        end
      end
    endcase
    return g;
  endfunction

  function automatic erm_sync_gen_s sync_pick(input int ch, input int c);
    erm_sync_gen_s g;
    g = '0;
    hit = 1'b1;
    if (c == 1) g.capture_timer_zero = 1'b1;
    else if (c == 2) g.main_timer_overflow = 1'b1;
    else if (c == 6) g.main_timer_compare_two = 1'b1;
    else if (ch == 0 && c >= 7 && c <= 12) g.port_c_line[c - 7] = 1'b1;
    else if (ch == 0 && c >= 13 && c <= 20) g.port_a_line[c - 13] = 1'b1;
    else if ((ch == 0 && c == 21) || (ch == 1 && c == 16)) g.capture_timer_one = 1'b1;
    else if (ch == 1 && c >= 8 && c <= 15) g.port_b_line[c - 8] = 1'b1;
    else begin
      g = '1;
      hit = 1'b0;
    end
    return g;
  endfunction

  function automatic logic cb(input int c, input int p);
    return 1'((c >> p) & 1);
  endfunction

  initial begin
    #1000000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    for (int a = 0; a < 36; a++) reg_read(a[7:0], 8'h00);
    reg_write(8'h06, 8'ha5);
    reg_read(8'h06, 8'h00);
    reg_write(8'h1e, 8'h5a);
    reg_read(8'h1e, 8'h5a);
    for (int ch = 0; ch < 4; ch++) begin
      reg_write(8'h12, 8'h03 + ch[7:0]);
      for (int c = 0; c < 23; c++) begin
        reg_write(8'h02 + ch[7:0], c[7:0]);
        ga = async_pick(ch, c);
        drive(ga, '0);
        chk_evt({hit, 14'h0});
      end
    end
    for (int ch = 0; ch < 2; ch++) begin
      reg_write(8'h12, 8'h01 + ch[7:0]);
      reg_write(8'h22, 8'h01 + ch[7:0]);
      for (int c = 0; c < 23; c++) begin
        reg_write(8'h0a + ch[7:0], c[7:0]);
        gs = sync_pick(ch, c);
        drive('0, gs);
        chk_evt({hit, 12'h0, hit, 1'b0});
      end
    end
    reg_write(8'h0a, 8'h07);
    reg_write(8'h0b, 8'h08);
    for (int k = 0; k < 4; k++) reg_write(8'h02 + k[7:0], 8'h0a);
    for (int v = 0; v < 9; v++) begin
      for (int u = 0; u < 15; u++) reg_write(u < 13 ? 8'h12 + u[7:0] : 8'h15 + u[7:0], v[7:0]);
      for (int p = 0; p < 3; p++) begin
        ga = '0;
        gs = '0;
        gs.port_c_line[0] = cb(1, p);
        gs.port_b_line[0] = cb(2, p);
        ga.port_a_line[0] = cb(3, p);
        ga.port_b_line[0] = cb(4, p);
        ga.port_c_line[0] = cb(5, p);
        ga.periodic_tap[0] = cb(6, p);
        drive(ga, gs);
        chk_evt({{13{v >= 1 && v <= 6 && cb(v, p)}}, {2{v <= 2 && cb(v, p)}}});
      end
    end
    drive('0, '0);
    reg_write(8'h02, 8'h00);
    reg_write(8'h1a, 8'h03);
    for (int k = 0; k < 6; k++) begin
      reg_write(8'h12, k[7:0] + 8'h01);
      reg_write(8'h22, k[7:0] + 8'h01);
      reg_write(k < 2 ? 8'h01 : 8'h00, 8'h01 << (k < 2 ? k : k - 2));
      chk_evt({1'b1, 7'h0, k == 2, 4'h0, k < 2, 1'b0});
      @(posedge ref_clk);
      #1;
      chk_evt(15'h0);
      reg_read(k < 2 ? 8'h01 : 8'h00, 8'h01 << (k < 2 ? k : k - 2));
    end
    reg_write(8'h00, 8'hf0);
    chk_evt(15'h0);
    reg_write(8'h02, 8'h01);
    reg_write(8'h12, 8'h03);
    ga = '0;
    ga.logic_table_zero_out = 1'b1;
    @(posedge ref_clk);
    pulse_mode <= 1'b1;
    fire <= 1'b1;
    a_req <= ga;
    @(posedge ref_clk);
    fire <= 1'b0;
    #1;
    chk_evt(15'h4040);
    @(posedge ref_clk);
    #1;
    chk_evt(15'h0);
    @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    @(posedge ref_clk);
    rst <= 1'b0;
    reg_read(8'h12, 8'h00);
    tally_and_finish();
  end
endmodule
